// >>> verilog/aap_pkg.sv
// Constants of the audio converter port register bank.
// Assumes a single 8-bit register port clocked by the master clock.
package aap_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIV = 8'h03;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_FMT = 8'h05;
  localparam logic [7:0] ADDR_CHN = 8'h06;
  localparam logic [7:0] ADDR_SLOT1 = 8'h07;
  localparam logic [7:0] ADDR_SLOT2 = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CS0 = 8'h0d;
  localparam logic [7:0] ADDR_CS4 = 8'h11;
  localparam logic [7:0] ADDR_CLR = 8'h13;
  localparam logic [7:0] ADDR_VREF = 8'h19;
  localparam logic [7:0] ADDR_PIN_AB = 8'h1b;
  localparam logic [7:0] ADDR_PIN_CD = 8'h1c;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIV = 8'h07;
  localparam logic [7:0] RST_MODE = 8'h05;
  localparam logic [2:0] RST_FMT = 3'h0;
  localparam logic [7:0] RST_CHN = 8'h01;
  localparam logic [5:0] RST_SLOT1 = 6'h00;
  localparam logic [4:0] RST_SLOT2 = 5'h01;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [39:0] RST_CS = 40'h0;
  localparam logic [1:0] RST_CLR = 2'h0;
  localparam logic RST_VREF = 1'b0;
  localparam logic [15:0] RST_PINS = 16'h0002;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_HALVE = 7;
  localparam int MODE_CINV = 6;
  localparam int MODE_FLEN_LO = 4;
  localparam int MODE_PULSE = 3;
  localparam int MODE_BINV = 2;
  localparam int MODE_WINV = 1;
  localparam int MODE_MEN = 0;
  localparam int FMT_EDGE = 2;
  localparam int FMT_LJ = 1;
  localparam int FMT_WLEN = 0;
  localparam int CHN_AUTO = 7;
  localparam int SLOT1_SINV = 5;
  localparam logic [1:0] FLEN_16 = 2'b10;
  localparam logic [7:0] MASK_USED = 8'hcf;
  // ----------------------------------------------------------------
  // Pin function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FN_SHUTDOWN = 4'h0;
  localparam logic [3:0] FN_AUX_IN = 4'h1;
  localparam logic [3:0] FN_AUX_OUT = 4'h2;
  localparam logic [3:0] FN_PEAK1 = 4'h5;
  localparam logic [3:0] FN_PEAK2 = 4'h6;
  localparam logic [3:0] FN_IRQ_OR = 4'h7;
  localparam logic [3:0] FN_SPDIF = 4'h8;
  localparam logic [3:0] FN_PWM = 4'h9;
  localparam logic [3:0] FN_RANGE1 = 4'ha;
  localparam logic [3:0] FN_RANGE2 = 4'hb;
  localparam logic [3:0] FN_MODCLK = 4'hc;
  localparam logic [3:0] FN_CONVCLK = 4'hd;
  localparam logic [3:0] FN_ZERO = 4'he;
  localparam logic [3:0] FN_ONE = 4'hf;
  // ----------------------------------------------------------------
  // Slot shifts
  // ----------------------------------------------------------------
  localparam logic [2:0] SH_32 = 3'h5;
  localparam logic [2:0] SH_16 = 3'h4;
endpackage : aap_pkg

// >>> verilog/aap_fifo_if.sv
// Carrier between the register bank and its sample FIFO.
// Assumes both ends share the master clock.
`timescale 1ns/1ps
interface aap_fifo_if #(parameter int WIDTH = 64);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface : aap_fifo_if

// >>> verilog/aap_fifo.sv
// Sample FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
module aap_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  aap_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign f.in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data = mem_q[rd_q];
  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_valid && f.out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && push) begin
      mem_q[wr_q] <= f.in_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (i_clk_en) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : aap_fifo

// >>> verilog/aap_regs.sv
// Serial audio port configuration bank with port timing, pin routing.
// Assumes one master clock; port pins arrive asynchronously.
//
// Functional notes
// - Bit clock generator runs at master clock over twice (divider plus one); reset seven.
// - Converter clock full rate when halve bit zero, half rate when one.
// - Converter clock invert bit inverts phase, only under forced phase.
// - Master slots are 32 bits for code 00, 16 bits for 10.
// - Pulse mode gives one bit wide select; otherwise 50 percent square.
// - Master enable generates and drives bit clock and word select.
// - Frame starts on select falling edge, or rising when edge bit set.
// - First data bit one bit after select edge, none when left justified.
// - Subframe holds 32 bits, or 16 bits when word length bit set.
// - Autodetect infers channel count from frame length in slave mode, else programmed.
// - Channel count field n means n plus one channels; reset two.
// - Slave mode inverts incoming bit clock when slave invert bit set.
// - Channel one data goes to slot n plus one; reset first slot.
// - Channel two data goes to slot n plus one; reset second slot.
// - Ranging interrupts pass only when their mask bit is one.
// - Immediate and held peak interrupts pass only when enabled.
// - Held peak interrupt clears while clear bit one, else holds.
// - Forty-bit status field feeds the S/PDIF channel-status bits.
// - Reference fast charge on when bit zero, off when one.
// - Each general pin routes the signal chosen by its function code.
// - After reset pin one selects aux output, others shutdown.
// - Invert bit used only under forced phase, else automatic phase.
`timescale 1ns/1ps
module aap_regs #(
  parameter int SMP_W = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_smp_valid,
  output logic o_smp_ready,
  input wire logic [2*SMP_W-1:0] i_smp_data,
  input wire logic i_bck,
  output logic o_bck,
  output logic o_bck_oe,
  input wire logic i_ws,
  output logic o_ws,
  output logic o_ws_oe,
  output logic o_sd,
  input wire logic i_force_phase,
  input wire logic i_auto_phase,
  output logic o_conv_clk,
  output logic [4:0] o_chan_count,
  input wire logic [1:0] i_peak_flag,
  input wire logic [1:0] i_ranging_active,
  output logic o_irq_any,
  output logic [39:0] o_spdif_status,
  output logic o_ref_fast_charge,
  input wire logic i_spdif_stream,
  input wire logic i_pwm,
  input wire logic i_mod_clk,
  input wire logic [3:0] i_aux_out,
  output logic [3:0] o_aux_in,
  output logic o_analog_off,
  input wire logic [3:0] i_pin,
  output logic [3:0] o_pin,
  output logic [3:0] o_pin_oe
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic [7:0] mode_q;
  logic [2:0] fmt_q;
  logic [7:0] chn_q;
  logic [5:0] slot1_q;
  logic [4:0] slot2_q;
  logic [7:0] mask_q;
  logic [39:0] cs_q;
  logic [1:0] clr_q;
  logic vref_q;
  logic [15:0] pins_q;
  logic [7:0] rd_d;
  logic wr;

  assign wr = i_clk_en && i_reg_wr;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_q <= aap_pkg::RST_DIV;
      mode_q <= aap_pkg::RST_MODE;
      fmt_q <= aap_pkg::RST_FMT;
      chn_q <= aap_pkg::RST_CHN;
      slot1_q <= aap_pkg::RST_SLOT1;
      slot2_q <= aap_pkg::RST_SLOT2;
      mask_q <= aap_pkg::RST_MASK;
      cs_q <= aap_pkg::RST_CS;
      clr_q <= aap_pkg::RST_CLR;
      vref_q <= aap_pkg::RST_VREF;
      pins_q <= aap_pkg::RST_PINS;
    end else if (wr) begin
      unique case (i_reg_addr)
        aap_pkg::ADDR_DIV: div_q <= i_reg_wdata;
        aap_pkg::ADDR_MODE: mode_q <= i_reg_wdata;
        aap_pkg::ADDR_FMT: fmt_q <= i_reg_wdata[2:0];
        aap_pkg::ADDR_CHN: chn_q <= i_reg_wdata & 8'h9f;
        aap_pkg::ADDR_SLOT1: slot1_q <= i_reg_wdata[5:0];
        aap_pkg::ADDR_SLOT2: slot2_q <= i_reg_wdata[4:0];
        aap_pkg::ADDR_MASK: mask_q <= i_reg_wdata & aap_pkg::MASK_USED;
        aap_pkg::ADDR_CLR: clr_q <= i_reg_wdata[1:0];
        aap_pkg::ADDR_VREF: vref_q <= i_reg_wdata[0];
        aap_pkg::ADDR_PIN_AB: pins_q[7:0] <= i_reg_wdata;
        aap_pkg::ADDR_PIN_CD: pins_q[15:8] <= i_reg_wdata;
        default: begin
          // Status bytes, low byte at the lowest offset
          if (i_reg_addr >= aap_pkg::ADDR_CS0 &&
              i_reg_addr <= aap_pkg::ADDR_CS4) begin
            cs_q[8*(i_reg_addr-aap_pkg::ADDR_CS0) +: 8] <= i_reg_wdata;
          end
        end
      endcase
    end
  end

  always_comb begin
    rd_d = 8'h00;
    unique case (i_reg_addr)
      aap_pkg::ADDR_DIV: rd_d = div_q;
      aap_pkg::ADDR_MODE: rd_d = mode_q;
      aap_pkg::ADDR_FMT: rd_d = {5'h00, fmt_q};
      aap_pkg::ADDR_CHN: rd_d = chn_q;
      aap_pkg::ADDR_SLOT1: rd_d = {2'h0, slot1_q};
      aap_pkg::ADDR_SLOT2: rd_d = {3'h0, slot2_q};
      aap_pkg::ADDR_MASK: rd_d = mask_q;
      aap_pkg::ADDR_CLR: rd_d = {6'h00, clr_q};
      aap_pkg::ADDR_VREF: rd_d = {7'h00, vref_q};
      aap_pkg::ADDR_PIN_AB: rd_d = pins_q[7:0];
      aap_pkg::ADDR_PIN_CD: rd_d = pins_q[15:8];
      default: begin
        if (i_reg_addr >= aap_pkg::ADDR_CS0 &&
            i_reg_addr <= aap_pkg::ADDR_CS4) begin
          rd_d = cs_q[8*(i_reg_addr-aap_pkg::ADDR_CS0) +: 8];
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_clk_en && i_reg_rd) begin
      o_reg_rdata <= rd_d;
    end
  end

  assign o_spdif_status = cs_q;
  assign o_ref_fast_charge = !vref_q;

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  logic conv_q;
  logic half_q;
  logic conv_d;
  logic phase_inv;

  // Forced phase takes the programmed invert, else the automatic choice
  assign phase_inv = i_force_phase ? mode_q[aap_pkg::MODE_CINV]
                                   : i_auto_phase;
  assign conv_d = (!mode_q[aap_pkg::MODE_HALVE] || half_q) ? !conv_q
                                                          : conv_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      conv_q <= 1'b0;
      half_q <= 1'b0;
      o_conv_clk <= 1'b0;
    end else if (i_clk_en) begin
      half_q <= !half_q;
      conv_q <= conv_d;
      o_conv_clk <= conv_d ^ phase_inv;
    end
  end

  // ----------------------------------------------------------------
  // Port pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bck_s1_q;
  logic [1:0] ws_s1_q;
  logic [3:0] pin_s1_q;
  logic [1:0] bck_s2_q;
  logic ws_s2_q;
  logic [3:0] pin_s2_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      bck_s1_q <= 2'h0;
      ws_s1_q <= 2'h0;
      pin_s1_q <= 4'h0;
      bck_s2_q <= 2'h0;
      ws_s2_q <= 1'b0;
      pin_s2_q <= 4'h0;
    end else if (i_clk_en) begin
      bck_s1_q <= {bck_s1_q[0], i_bck};
      ws_s1_q <= {ws_s1_q[0], i_ws};
      pin_s1_q <= i_pin;
      bck_s2_q <= {bck_s2_q[0], bck_s1_q[1]};
      ws_s2_q <= ws_s1_q[1];
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Bit and frame timing
  // ----------------------------------------------------------------
  logic master;
  logic [7:0] cnt_q;
  logic bclk_q;
  logic tick;
  logic slave_fall;
  logic bit_adv;
  logic [10:0] bit_q;
  logic [10:0] nidx;
  logic [10:0] fbits;
  logic [2:0] slot_sh;
  logic [2:0] word_sh;
  logic frame_start;
  logic ws_prev_q;
  logic [4:0] det_q;
  logic [4:0] eff_ch;
  logic ws_raw;

  assign master = mode_q[aap_pkg::MODE_MEN];
  // At or past the divider, so a smaller divider written mid-count wraps now
  assign tick = (cnt_q >= div_q);
  // Slave bit clock, optionally inverted; data moves on its falling edge
  assign slave_fall = ((bck_s2_q[1] ^ slot1_q[aap_pkg::SLOT1_SINV]) &&
                      !(bck_s2_q[0] ^ slot1_q[aap_pkg::SLOT1_SINV]));
  assign bit_adv = master ? (tick && bclk_q) : slave_fall;
  assign word_sh = fmt_q[aap_pkg::FMT_WLEN] ? aap_pkg::SH_16
                                            : aap_pkg::SH_32;
  assign slot_sh = !master ? word_sh :
                   (mode_q[5:4] == aap_pkg::FLEN_16) ? aap_pkg::SH_16
                                                     : aap_pkg::SH_32;
  assign fbits = 11'({6'h00, chn_q[4:0]} + 11'h001) << slot_sh;
  // Detection counts only from bit clocks seen in slave mode
  assign eff_ch = (!master && chn_q[aap_pkg::CHN_AUTO]) ? det_q
                                                       : chn_q[4:0];
  // At or past the last bit, so a shorter frame written mid-frame still wraps
  assign frame_start = master ? (bit_q >= fbits - 11'h001)
    : (fmt_q[aap_pkg::FMT_EDGE] ? (!ws_prev_q && ws_s2_q)
                                : (ws_prev_q && !ws_s2_q));
  assign nidx = frame_start ? 11'h000
              : (&bit_q ? bit_q : bit_q + 11'h001);
  assign ws_raw = mode_q[aap_pkg::MODE_PULSE] ? (nidx == 11'h000)
                : (nidx < (fbits >> 1));
  assign o_bck = bclk_q ^ mode_q[aap_pkg::MODE_BINV];
  assign o_bck_oe = master;
  assign o_ws_oe = master;
  assign o_chan_count = eff_ch;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
      bclk_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!master || tick) begin
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
      if (master && tick) begin
        bclk_q <= !bclk_q;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      bit_q <= 11'h000;
      ws_prev_q <= 1'b0;
      det_q <= 5'h01;
      o_ws <= 1'b0;
    end else if (i_clk_en && bit_adv) begin
      bit_q <= nidx;
      ws_prev_q <= ws_s2_q;
      if (master) begin
        // Frame edge direction is set by the edge bit, then inverted when the invert bit is set
        o_ws <= (fmt_q[aap_pkg::FMT_EDGE] ? ws_raw : !ws_raw) ^
                mode_q[aap_pkg::MODE_WINV];
      end else if (frame_start) begin
        det_q <= 5'(({1'b0, bit_q} + 12'h001) >> word_sh) - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample FIFO and serial data
  // ----------------------------------------------------------------
  aap_fifo_if #(.WIDTH(2*SMP_W)) fq ();

  aap_fifo #(
    .WIDTH(2*SMP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .f(fq.fifo)
  );

  logic [11:0] dpos;
  logic [10:0] slot;
  logic [4:0] bis;
  logic load;
  logic [2*SMP_W-1:0] pair_q;
  logic [2*SMP_W-1:0] pair;
  logic [SMP_W-1:0] smp;
  logic sd_d;
  logic hit1;
  logic hit2;

  assign fq.in_valid = i_smp_valid;
  assign fq.in_data = i_smp_data;
  assign o_smp_ready = fq.in_ready;
  // Data lags the select edge by one bit unless left justified
  assign dpos = fmt_q[aap_pkg::FMT_LJ] ? {1'b0, nidx}
                                       : {1'b0, nidx} - 12'h001;
  assign slot = dpos[10:0] >> slot_sh;
  assign bis = dpos[4:0] & 5'((11'h001 << slot_sh) - 11'h001);
  assign load = bit_adv && (dpos == 12'h000);
  assign fq.out_ready = i_clk_en && load;
  assign pair = load ? (fq.out_valid ? fq.out_data : '0) : pair_q;
  assign hit1 = (slot == {6'h00, slot1_q[4:0]});
  assign hit2 = (slot == {6'h00, slot2_q});
  assign smp = hit1 ? pair[SMP_W-1:0] : pair[2*SMP_W-1:SMP_W];

  always_comb begin
    sd_d = 1'b0;
    if (!dpos[11] && (slot <= {6'h00, eff_ch}) && (hit1 || hit2) &&
        ({3'h0, bis} < (8'h01 << word_sh))) begin
      sd_d = smp[SMP_W-1-int'(bis)];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pair_q <= '0;
      o_sd <= 1'b0;
    end else if (i_clk_en && bit_adv) begin
      pair_q <= pair;
      o_sd <= sd_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt masking and held peak flags
  // ----------------------------------------------------------------
  logic [1:0] held_q;
  logic [5:0] irq_vec;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      held_q <= 2'h0;
    end else if (i_clk_en) begin
      held_q <= i_peak_flag | (held_q & ~clr_q);
    end
  end

  assign irq_vec = {i_ranging_active & mask_q[7:6],
                    i_peak_flag & mask_q[3:2],
                    held_q & mask_q[1:0]};
  assign o_irq_any = |irq_vec;

  // ----------------------------------------------------------------
  // General pin routing
  // ----------------------------------------------------------------
  logic [3:0] shut;

  for (genvar p = 0; p < 4; p++) begin : g_pin
    logic [3:0] fn;
    assign fn = pins_q[4*p +: 4];
    assign shut[p] = (fn == aap_pkg::FN_SHUTDOWN);
    assign o_aux_in[p] = (fn == aap_pkg::FN_AUX_IN) && pin_s2_q[p];
    always_comb begin
      o_pin[p] = 1'b0;
      o_pin_oe[p] = 1'b1;
      unique case (fn)
        aap_pkg::FN_AUX_OUT: o_pin[p] = i_aux_out[p];
        aap_pkg::FN_PEAK1: o_pin[p] = irq_vec[2];
        aap_pkg::FN_PEAK2: o_pin[p] = irq_vec[3];
        aap_pkg::FN_IRQ_OR: o_pin[p] = o_irq_any;
        aap_pkg::FN_SPDIF: o_pin[p] = i_spdif_stream;
        aap_pkg::FN_PWM: o_pin[p] = i_pwm;
        aap_pkg::FN_RANGE1: o_pin[p] = irq_vec[4];
        aap_pkg::FN_RANGE2: o_pin[p] = irq_vec[5];
        aap_pkg::FN_MODCLK: o_pin[p] = i_mod_clk;
        aap_pkg::FN_CONVCLK: o_pin[p] = o_conv_clk;
        aap_pkg::FN_ZERO: o_pin[p] = 1'b0;
        aap_pkg::FN_ONE: o_pin[p] = 1'b1;
        default: o_pin_oe[p] = 1'b0;
      endcase
    end
  end

  assign o_analog_off = |shut;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_div_reset: assert property (@(posedge i_sys_clk)
    i_rst |=> (div_q == aap_pkg::RST_DIV && chn_q == aap_pkg::RST_CHN))
    else $error("divider or channel count reset value wrong");
  a_pin_reset: assert property (@(posedge i_sys_clk)
    i_rst |=> (pins_q == aap_pkg::RST_PINS))
    else $error("pin functions reset value wrong");
  a_tick_wrap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_clk_en && master && cnt_q == div_q) |=> (cnt_q == 8'h00))
    else $error("bit clock divider did not wrap at divider value");
  a_conv_full: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_clk_en && !mode_q[aap_pkg::MODE_HALVE]) |=> conv_q != $past(conv_q))
    else $error("converter clock not at full rate");
  a_conv_phase: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_clk_en && i_force_phase) |=>
      (o_conv_clk == (conv_q ^ $past(mode_q[aap_pkg::MODE_CINV]))))
    else $error("forced converter phase not applied");
  a_port_drive: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    master |-> (o_bck_oe && o_ws_oe))
    else $error("master port pins not driven");
  a_frame_wrap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_clk_en && master && bit_adv && bit_q == fbits - 11'h001) |=>
      (bit_q == 11'h000))
    else $error("master frame did not wrap at frame length");
  a_held_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_clk_en && held_q[0] && !clr_q[0]) |=> held_q[0])
    else $error("held peak flag lost without clear");
  a_held_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_clk_en && clr_q[0] && !i_peak_flag[0]) |=> !held_q[0])
    else $error("held peak flag not cleared");
  a_mask_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (mask_q == 8'h00) |-> !o_irq_any)
    else $error("interrupt passed while all masked");
  a_fast_chg: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr && i_reg_addr == aap_pkg::ADDR_VREF) |=>
      (o_ref_fast_charge == !$past(i_reg_wdata[0])))
    else $error("fast charge control wrong after write");

  c_master_frame: cover property (@(posedge i_sys_clk)
    i_clk_en && master && bit_adv && frame_start);
  c_slave_frame: cover property (@(posedge i_sys_clk)
    i_clk_en && !master && bit_adv && frame_start);
  c_held_set: cover property (@(posedge i_sys_clk) $rose(held_q[1]));
  c_fifo_full: cover property (@(posedge i_sys_clk)
    i_smp_valid && !o_smp_ready);
endmodule : aap_regs

// >>> tb/aap_rx_model.sv
// Serial receiver model: idle port lines and frame length count.
// Assumes the block is master; frames start on select falling.
`timescale 1ns/1ps
module aap_rx_model (
  input wire logic i_sys_clk,
  input wire logic i_ws,
  output logic o_bck,
  output logic o_ws,
  output logic [15:0] o_frame_clks
);
  logic ws_q = 1'b0;
  logic [15:0] cnt_q = 16'h0000;
  initial {o_bck, o_ws, o_frame_clks} = 18'h00000;
  // Undriven lines toggle so a stale level never looks valid
  always @(posedge i_sys_clk) begin
    o_bck <= ~o_bck;
    o_ws <= o_bck;
    ws_q <= i_ws;
    cnt_q <= cnt_q + 16'h0001;
    if (ws_q && !i_ws) begin
      o_frame_clks <= cnt_q + 16'h0001;
      cnt_q <= 16'h0000;
    end
  end
endmodule : aap_rx_model

// >>> tb/aap_regs_tb.sv
// Self-checking bench of the port register bank.
// Assumes a 40 MHz clock and the receiver model on the serial port.
`timescale 1ns/1ps
module aap_regs_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst, i_clk_en, i_reg_wr, i_reg_rd, i_smp_valid, o_smp_ready;
  logic i_force_phase, i_auto_phase, i_spdif_stream, i_pwm, i_mod_clk;
  logic i_bck, o_bck, o_bck_oe, i_ws, o_ws, o_ws_oe, o_sd, o_conv_clk;
  logic o_irq_any, o_ref_fast_charge, o_analog_off;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [15:0] clks;
  logic [63:0] i_smp_data;
  logic [4:0] o_chan_count;
  logic [1:0] i_peak_flag, i_ranging_active;
  logic [39:0] o_spdif_status;
  logic [3:0] i_aux_out, o_aux_in, i_pin, o_pin, o_pin_oe;
  logic [15:0] rst_tab [6] = '{16'h0307, 16'h0601, 16'h0700, 16'h0801,
    16'h0c00, 16'h1b02};
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  always #12.5 i_sys_clk = ~i_sys_clk;
  aap_regs uut (.i_sys_clk, .i_rst, .i_clk_en, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_smp_valid, .o_smp_ready,
    .i_smp_data, .i_bck, .o_bck, .o_bck_oe, .i_ws, .o_ws, .o_ws_oe, .o_sd,
    .i_force_phase, .i_auto_phase, .o_conv_clk, .o_chan_count,
    .i_peak_flag, .i_ranging_active, .o_irq_any, .o_spdif_status,
    .o_ref_fast_charge, .i_spdif_stream, .i_pwm, .i_mod_clk, .i_aux_out,
    .o_aux_in, .o_analog_off, .i_pin, .o_pin, .o_pin_oe);
  aap_rx_model rx (.i_sys_clk, .i_ws(o_ws), .o_bck(i_bck), .o_ws(i_ws),
    .o_frame_clks(clks));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    {i_reg_rd, i_reg_addr} <= {1'b1, a};
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rdata, e);
  endtask : reg_rd
  task automatic frame(input logic [15:0] e);
    repeat (3) @(negedge o_ws);
    repeat (2) @(posedge i_sys_clk);
    chk(clks, e);
  endtask : frame
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_errors++;
      finish_test();
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    {i_rst, i_clk_en, i_reg_wr, i_reg_rd, i_smp_valid} = 5'b11000;
    {i_force_phase, i_auto_phase, i_spdif_stream, i_pwm, i_mod_clk} = 5'h10;
    {i_reg_addr, i_reg_wdata, i_smp_data} = 80'h0;
    {i_peak_flag, i_ranging_active, i_aux_out, i_pin} = 12'h01c;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    foreach (rst_tab[k]) reg_rd(rst_tab[k][15:8], rst_tab[k][7:0]);
    reg_rd(8'h0a, 8'h00);
    chk({o_pin_oe, o_pin[0], o_ref_fast_charge, o_analog_off}, 7'h0f);
    $display("test reset values done");
    frame(16'd1024);
    reg_wr(aap_pkg::ADDR_DIV, 8'h01);
    reg_wr(aap_pkg::ADDR_CHN, 8'h00);
    chk(o_chan_count, 5'h00);
    frame(16'd128);
    reg_wr(aap_pkg::ADDR_MODE, 8'h25);
    frame(16'd64);
    n = 0;
    @(posedge i_sys_clk);
    i_smp_valid <= 1'b1;
    repeat (12) begin
      @(posedge i_sys_clk);
      if (o_smp_ready === 1'b1) n++;
      i_smp_data <= i_smp_data + 64'h1;
    end
    i_smp_valid <= 1'b0;
    chk(n inside {8, 9}, 1'b1);
    repeat (200) @(posedge i_sys_clk);
    chk(o_smp_ready, 1'b1);
    reg_wr(aap_pkg::ADDR_MODE, 8'h04);
    chk({o_bck_oe, o_ws_oe}, 2'b00);
    $display("test serial frame done");
    @(posedge i_sys_clk);
    {i_ranging_active, i_peak_flag} <= 4'b1001;
    reg_wr(aap_pkg::ADDR_MASK, 8'h40);
    chk(o_irq_any, 1'b0);
    reg_wr(aap_pkg::ADDR_MASK, 8'h80);
    chk(o_irq_any, 1'b1);
    reg_wr(aap_pkg::ADDR_MASK, 8'h01);
    i_peak_flag <= 2'b00;
    reg_rd(aap_pkg::ADDR_MASK, 8'h01);
    chk(o_irq_any, 1'b1);
    reg_wr(aap_pkg::ADDR_CLR, 8'h01);
    reg_rd(aap_pkg::ADDR_CLR, 8'h01);
    chk(o_irq_any, 1'b0);
    reg_wr(aap_pkg::ADDR_CS0, 8'ha5);
    reg_wr(aap_pkg::ADDR_CS4, 8'h3c);
    chk(o_spdif_status, 40'h3c000000a5);
    reg_wr(aap_pkg::ADDR_VREF, 8'h01);
    reg_wr(aap_pkg::ADDR_PIN_AB, 8'hfe);
    chk({o_pin_oe[1:0], o_pin[1:0], o_ref_fast_charge}, 5'h1c);
    reg_wr(aap_pkg::ADDR_PIN_CD, 8'h11);
    chk({o_aux_in, o_analog_off}, 5'h18);
    $display("test irq status pins done");
    finish_test();
  end
endmodule : aap_regs_tb
